// ==== design/flic_regs.svh ====
`ifndef FLIC_REGS_SVH
`define FLIC_REGS_SVH

// Register byte offsets on the AXI4-Lite port
`define FLIC_ADDR_FLAGS     8'h00
`define FLIC_ADDR_ENABLE    8'h04
`define FLIC_ADDR_PRIO_LO   8'h08
`define FLIC_ADDR_PRIO_HI   8'h0C
`define FLIC_ADDR_EXT_MODE  8'h10
`define FLIC_ADDR_STATUS    8'h14
`define FLIC_ADDR_EVT_STAT  8'h18
`define FLIC_ADDR_EVT_MASK  8'h1C

// AXI responses
`define FLIC_RESP_OKAY      2'h0
`define FLIC_RESP_SLVERR    2'h2

// Flag bit positions in the flag register
`define FLIC_F_SUPPLY       0
`define FLIC_F_EXT0         1
`define FLIC_F_TIMER_A      2
`define FLIC_F_EXT1         3
`define FLIC_F_TIMER_B      4
`define FLIC_F_SER_A_RX     5
`define FLIC_F_SER_A_TX     6
`define FLIC_F_TIMER_C_OVF  7
`define FLIC_F_TIMER_C_EXT  8
`define FLIC_F_SER_B_RX     9
`define FLIC_F_SER_B_TX     10
`define FLIC_F_EXT2         11
`define FLIC_F_WATCHDOG     15

// Source indices in natural order
`define FLIC_NUM_SRC        13
`define FLIC_SRC_SUPPLY     4'h0
`define FLIC_SRC_EXT0       4'h1
`define FLIC_SRC_TIMER_A    4'h2
`define FLIC_SRC_EXT1       4'h3
`define FLIC_SRC_TIMER_B    4'h4

// Enable register: bits 0..12 per source, bit 13 global enable
`define FLIC_EN_GLOBAL      13

// Event status bits
`define FLIC_EV_TAKEN       0
`define FLIC_EV_SUPPLY      1

// Fixed level of the supply-drop source
`define FLIC_LVL_SUPPLY     3'h4

// Vector per source in natural order
`define FLIC_VEC_0          8'h33
`define FLIC_VEC_1          8'h03
`define FLIC_VEC_2          8'h0B
`define FLIC_VEC_3          8'h13
`define FLIC_VEC_4          8'h1B
`define FLIC_VEC_5          8'h23
`define FLIC_VEC_6          8'h2B
`define FLIC_VEC_7          8'h3B
`define FLIC_VEC_8          8'h43
`define FLIC_VEC_9          8'h4B
`define FLIC_VEC_10         8'h53
`define FLIC_VEC_11         8'h5B
`define FLIC_VEC_12         8'h63

// Reset values
`define FLIC_RST_EXT_PREV   6'h3F
`define FLIC_RST_EXT_MODE   2'h0

`endif

// ==== design/flic_pkg.sv ====
package flic_pkg;

  // Complete state of the controller
  typedef struct packed {
    logic [15:0] flags;
    logic [13:0] enable;
    logic [12:0] prio_lo;
    logic [12:0] prio_hi;
    logic [1:0] edge_mode;
    logic [4:0] in_service;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [5:0] ext_prev;
    logic supply_prev;
    logic req;
    logic [7:0] vector;
    logic [2:0] level;
    logic [3:0] src;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } flic_state_t;

  // Arbitration key: valid, level, inverted natural rank
  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [3:0] rank;
  } flic_key_t;

endpackage

// ==== design/flic_arbiter.sv ====
`include "flic_regs.svh"

module flic_arbiter (
  // Requests and their levels, three bits per source
  input wire logic [12:0] src_req,
  input wire logic [38:0] src_level,
  // Winner
  output logic found,
  output logic [3:0] win_src,
  output logic [2:0] win_level
);

  flic_pkg::flic_key_t keys [`FLIC_NUM_SRC];
  flic_pkg::flic_key_t best;

  // Build one key per source; lower index gives higher rank
  for (genvar i = 0; i < `FLIC_NUM_SRC; i++) begin : g_key
    assign keys[i].valid = src_req[i];
    assign keys[i].level = src_level[3*i +: 3];
    assign keys[i].rank = 4'(12 - i);
  end

  // Highest key wins: level first, natural order breaks ties
  always_comb begin
    best = '0;
    for (int i = 0; i < `FLIC_NUM_SRC; i++) begin
      if (keys[i] > best) begin
        best = keys[i];
      end
    end
  end

  assign found = best.valid;
  assign win_src = 4'(4'hC - best.rank);
  assign win_level = best.level;

endmodule

// ==== design/flic_top.sv ====
// How it works
// - Five levels, 4 highest down to 0; level 4 only for supply drop.
// - Other sources take level 3..0 from their own high and low priority bits.
// - Enabled pending supply drop beats every other request regardless of priorities.
// - Ties at the highest active level go to the first in natural order.
// - Natural order: supply, ext0, timer a, ext1, timer b, serial a, timer c, ...
// - Vectors in natural order 33h,03h,0Bh,13h,1Bh,23h,2Bh,3Bh,43h..63h.
// - Enabled supply drop request vectors to 33h.
// - Flags set on their condition whether or not enabled.
// - Non-automatic flags stay set until software writes one to clear.
// - Timer a and b flags clear by hardware when their vector is taken.
// - Edge-mode ext0/ext1 flags clear by hardware when vector is taken.
// - Level-mode ext0/ext1 flags follow the pin level directly.
// - Supply drop flag set on each drop below threshold, cleared only by software.
// - Supply drop requests only while its enable is set; flag still records.
// - Supply drop gated by own enable only, not by the global enable.
`include "flic_regs.svh"

module flic_top (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt sources
  input wire logic supply_low,
  input wire logic [5:0] ext_line_n,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic timer_c_ovf,
  input wire logic timer_c_ext,
  input wire logic serial_a_rx,
  input wire logic serial_a_tx,
  input wire logic serial_b_rx,
  input wire logic serial_b_tx,
  input wire logic watchdog_evt,
  // Processor core
  input wire logic core_ack,
  input wire logic core_reti,
  output logic core_irq_req,
  output logic [7:0] core_vector,
  output logic [2:0] core_level,
  output logic [3:0] core_src,
  // Event interrupt
  output logic irq
);

  localparam logic [7:0] VEC [`FLIC_NUM_SRC] = '{
    `FLIC_VEC_0, `FLIC_VEC_1, `FLIC_VEC_2, `FLIC_VEC_3, `FLIC_VEC_4,
    `FLIC_VEC_5, `FLIC_VEC_6, `FLIC_VEC_7, `FLIC_VEC_8, `FLIC_VEC_9,
    `FLIC_VEC_10, `FLIC_VEC_11, `FLIC_VEC_12
  };

  flic_pkg::flic_state_t s_q;
  flic_pkg::flic_state_t s_d;

  logic [12:0] src_req;
  logic [38:0] src_level;
  logic found;
  logic [3:0] win_src;
  logic [2:0] win_level;
  logic [2:0] cur_level;
  logic cur_busy;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Per-source request terms
  // flag and enable
  always_comb begin
    src_req = '0;
    src_req[0] = s_q.flags[`FLIC_F_SUPPLY] & s_q.enable[0];
    src_req[1] = s_q.flags[`FLIC_F_EXT0];
    src_req[2] = s_q.flags[`FLIC_F_TIMER_A];
    src_req[3] = s_q.flags[`FLIC_F_EXT1];
    src_req[4] = s_q.flags[`FLIC_F_TIMER_B];
    src_req[5] = s_q.flags[`FLIC_F_SER_A_RX] | s_q.flags[`FLIC_F_SER_A_TX];
    src_req[6] = s_q.flags[`FLIC_F_TIMER_C_OVF] | s_q.flags[`FLIC_F_TIMER_C_EXT];
    src_req[7] = s_q.flags[`FLIC_F_SER_B_RX] | s_q.flags[`FLIC_F_SER_B_TX];
    src_req[11:8] = s_q.flags[`FLIC_F_EXT2 +: 4];
    src_req[12] = s_q.flags[`FLIC_F_WATCHDOG];
    src_req[12:1] = src_req[12:1] & s_q.enable[12:1] & {12{s_q.enable[`FLIC_EN_GLOBAL]}};
  end

  // Levels: fixed 4 for supply drop, programmed for the rest
  // Bit 2 stays zero for programmed sources, so only supply drop reaches 4
  // level 4 reserved
  assign src_level[2:0] = `FLIC_LVL_SUPPLY;
  for (genvar i = 1; i < `FLIC_NUM_SRC; i++) begin : g_lvl
    assign src_level[3*i +: 3] = {1'b0, s_q.prio_hi[i], s_q.prio_lo[i]};
  end

  // supply drop at level 4 wins
  flic_arbiter u_arb (
    .src_req(src_req),
    .src_level(src_level),
    .found(found),
    .win_src(win_src),
    .win_level(win_level)
  );

  // Highest level currently in service
  // Highest set bit wins, so a nested routine hides the levels below it
  always_comb begin
    cur_level = 3'h0;
    cur_busy = |s_q.in_service;
    for (int i = 0; i < 5; i++) begin
      if (s_q.in_service[i]) begin
        cur_level = 3'(i);
      end
    end
  end

  // Handshake outputs
  // Held low while an answer is open: one write and one read at a time
  assign awready = ~s_q.aw_held & ~s_q.bvalid;
  assign wready = ~s_q.w_held & ~s_q.bvalid;
  assign arready = ~s_q.rvalid;

  // Next state
  always_comb begin
    logic aw_fire;
    logic w_fire;
    logic do_wr;
    logic ack_take;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] lane;
    logic [15:0] flag_set;
    logic [5:0] ext_fall;
    logic [7:0] ra;
    s_d = s_q;
    aw_fire = awvalid & awready;
    w_fire = wvalid & wready;
    wa = s_q.aw_held ? s_q.aw_addr : awaddr;
    wd = s_q.w_held ? s_q.w_data : wdata;
    ws = s_q.w_held ? s_q.w_strb : wstrb;
    lane = merge(32'h0000_0000, wd, ws);
    do_wr = (s_q.aw_held | aw_fire) & (s_q.w_held | w_fire) & ~s_q.bvalid;
    ack_take = core_ack & s_q.req;
    ra = {araddr[7:2], 2'h0};
    ext_fall = s_q.ext_prev & ~ext_line_n;
    flag_set = '0;

    // Write channel capture
    // Address and data come in either order; the first one is parked
    if (aw_fire & ~do_wr) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_fire & ~do_wr) begin
      s_d.w_held = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid & bready) begin
      s_d.bvalid = 1'b0;
    end

    // Software writes: flags and event status are write-one-to-clear
    // software clear
    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `FLIC_RESP_OKAY;
      wa = {wa[7:2], 2'h0};
      if (wa == `FLIC_ADDR_FLAGS) begin
        s_d.flags = s_q.flags & ~lane[15:0];
      end else if (wa == `FLIC_ADDR_ENABLE) begin
        s_d.enable = 14'(merge(32'(s_q.enable), wd, ws));
      end else if (wa == `FLIC_ADDR_PRIO_LO) begin
        s_d.prio_lo = 13'(merge(32'(s_q.prio_lo), wd, ws));
      end else if (wa == `FLIC_ADDR_PRIO_HI) begin
        s_d.prio_hi = 13'(merge(32'(s_q.prio_hi), wd, ws));
      end else if (wa == `FLIC_ADDR_EXT_MODE) begin
        s_d.edge_mode = 2'(merge(32'(s_q.edge_mode), wd, ws));
      end else if (wa == `FLIC_ADDR_STATUS) begin
        s_d.bresp = `FLIC_RESP_OKAY;
      end else if (wa == `FLIC_ADDR_EVT_STAT) begin
        s_d.evt_status = s_q.evt_status & ~lane[1:0];
      end else if (wa == `FLIC_ADDR_EVT_MASK) begin
        s_d.evt_mask = 2'(merge(32'(s_q.evt_mask), wd, ws));
      end else begin
        s_d.bresp = `FLIC_RESP_SLVERR;
      end
    end

    // Read channel
    if (s_q.rvalid & rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid & arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `FLIC_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (ra == `FLIC_ADDR_FLAGS) begin
        s_d.rdata = 32'(s_q.flags);
      end else if (ra == `FLIC_ADDR_ENABLE) begin
        s_d.rdata = 32'(s_q.enable);
      end else if (ra == `FLIC_ADDR_PRIO_LO) begin
        s_d.rdata = 32'(s_q.prio_lo);
      end else if (ra == `FLIC_ADDR_PRIO_HI) begin
        s_d.rdata = 32'(s_q.prio_hi);
      end else if (ra == `FLIC_ADDR_EXT_MODE) begin
        s_d.rdata = 32'(s_q.edge_mode);
      end else if (ra == `FLIC_ADDR_STATUS) begin
        s_d.rdata = {8'h00, s_q.src, s_q.level, s_q.req, 3'h0, s_q.in_service, s_q.vector};
      end else if (ra == `FLIC_ADDR_EVT_STAT) begin
        s_d.rdata = 32'(s_q.evt_status);
      end else if (ra == `FLIC_ADDR_EVT_MASK) begin
        s_d.rdata = 32'(s_q.evt_mask);
      end else begin
        s_d.rresp = `FLIC_RESP_SLVERR;
      end
    end

    // Hardware clears on vector taken
    // The source and level shown are the ones the core just took
    if (ack_take) begin
      if (s_q.src == `FLIC_SRC_EXT0 && s_q.edge_mode[0]) begin
        s_d.flags[`FLIC_F_EXT0] = 1'b0;
      end
      if (s_q.src == `FLIC_SRC_EXT1 && s_q.edge_mode[1]) begin
        s_d.flags[`FLIC_F_EXT1] = 1'b0;
      end
      if (s_q.src == `FLIC_SRC_TIMER_A) begin
        s_d.flags[`FLIC_F_TIMER_A] = 1'b0;
      end
      if (s_q.src == `FLIC_SRC_TIMER_B) begin
        s_d.flags[`FLIC_F_TIMER_B] = 1'b0;
      end
    end

    // Event capture; sets win over any clear in the same cycle
    // set regardless of enable
    flag_set[`FLIC_F_SUPPLY] = supply_low & ~s_q.supply_prev;
    flag_set[`FLIC_F_EXT0] = ext_fall[0];
    flag_set[`FLIC_F_TIMER_A] = timer_a_ovf;
    flag_set[`FLIC_F_EXT1] = ext_fall[1];
    flag_set[`FLIC_F_TIMER_B] = timer_b_ovf;
    flag_set[`FLIC_F_SER_A_RX] = serial_a_rx;
    flag_set[`FLIC_F_SER_A_TX] = serial_a_tx;
    flag_set[`FLIC_F_TIMER_C_OVF] = timer_c_ovf;
    flag_set[`FLIC_F_TIMER_C_EXT] = timer_c_ext;
    flag_set[`FLIC_F_SER_B_RX] = serial_b_rx;
    flag_set[`FLIC_F_SER_B_TX] = serial_b_tx;
    flag_set[`FLIC_F_EXT2 +: 4] = ext_fall[5:2];
    flag_set[`FLIC_F_WATCHDOG] = watchdog_evt;
    s_d.flags = s_d.flags | flag_set;
    if (!s_q.edge_mode[0]) begin
      s_d.flags[`FLIC_F_EXT0] = ~ext_line_n[0];
    end
    if (!s_q.edge_mode[1]) begin
      s_d.flags[`FLIC_F_EXT1] = ~ext_line_n[1];
    end
    s_d.ext_prev = ext_line_n;
    s_d.supply_prev = supply_low;

    // In-service levels: push on vector taken, pop on return
    // Return and take in one cycle touch different levels
    if (core_reti && cur_busy) begin
      s_d.in_service[cur_level] = 1'b0;
    end
    if (ack_take) begin
      s_d.in_service[s_q.level] = 1'b1;
    end

    // Registered request toward the core; dropped in the cycle after an ack
    // A request may stay up one cycle after software clears its flag
    // strictly higher level
    s_d.req = found & ~ack_take & (~cur_busy | (win_level > cur_level));
    s_d.vector = VEC[win_src];
    s_d.level = win_level;
    s_d.src = win_src;

    // Sticky events; set wins over clear
    if (ack_take) begin
      s_d.evt_status[`FLIC_EV_TAKEN] = 1'b1;
    end
    if (flag_set[`FLIC_F_SUPPLY]) begin
      s_d.evt_status[`FLIC_EV_SUPPLY] = 1'b1;
    end
  end

  // State register with clock enable
  // Synchronous reset; ce low holds every bit, bus handshakes included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ext_prev <= `FLIC_RST_EXT_PREV;
      s_q.edge_mode <= `FLIC_RST_EXT_MODE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Registered outputs, and irq decoded from registered bits
  // Data outputs come straight from flip-flops
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign core_irq_req = s_q.req;
  assign core_vector = s_q.vector;
  assign core_level = s_q.level;
  assign core_src = s_q.src;
  assign irq = |(s_q.evt_status & s_q.evt_mask);

endmodule

// ==== verif/flic_core_model.sv ====
module flic_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic allow,
  input wire logic ret,
  // Core link
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector,
  output logic core_ack,
  output logic core_reti,
  // Last taken vector and take count
  output logic [7:0] tv,
  output logic [7:0] ntk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Take a shown vector when allowed, one pulse per request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ack <= 1'h0;
      core_reti <= 1'h0;
      tv <= 8'h00;
      ntk <= 8'h00;
    end else begin
      core_ack <= core_irq_req && allow && !core_ack;
      core_reti <= ret && !core_reti; // Single return pulse
      if (core_ack && core_irq_req) begin
        tv <= core_vector;
        ntk <= ntk + 8'h01;
      end
    end
  end
endmodule

// ==== verif/flic_checker.sv ====
module flic_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Core link
  input wire logic core_ack,
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector,
  input wire logic [2:0] core_level,
  input wire logic [3:0] core_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // Vector of each source in natural order
  localparam logic [7:0] VT [13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B,
    8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  vec_map_a: assert property (core_irq_req |-> core_vector == VT[core_src])
    else $error("vector does not match source");
  sup_lvl_a: assert property (core_irq_req && core_src == 4'h0 |-> core_level == 3'h4)
    else $error("supply drop not at top level");
  lvl_rng_a: assert property (core_irq_req && core_src != 4'h0 |-> core_level <= 3'h3)
    else $error("source level above three");
  ack_drop_a: assert property (core_irq_req && core_ack |=> !core_irq_req)
    else $error("request held after take");
  wr_ans_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write answer late");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer open");
  rd_ans_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rd_done_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer not released");

  // Main scenarios
  cover property (core_ack && core_irq_req && core_src == 4'h0);
  cover property (core_ack && core_irq_req && core_level == 3'h2);
  cover property (bvalid && bresp == 2'h2);
endmodule

bind flic_top flic_checker u_chk (.*);

// ==== verif/tb_top.sv ====
`include "flic_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus and core link
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic core_ack, core_reti, core_irq_req, allow, ret, ce;
  logic [7:0] awaddr, araddr, core_vector, tv, ntk, n;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, core_src;
  logic [1:0] bresp, rresp;
  logic [2:0] core_level;
  // Source events in natural order, then second timer c and serial inputs
  logic [15:0] ev;
  int error_cnt, checks;
  // Vector and flag bit of each source
  logic [7:0] vt [13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B,
    8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  int fp [13] = '{0, 1, 2, 3, 4, 5, 7, 10, 11, 12, 13, 14, 15};
  // Source and flag bit of events 13 to 15
  int ai [3] = '{6, 5, 7};
  int ab [3] = '{8, 6, 9};

  flic_top DUT (.*, .ce(ce), .supply_low(ev[0]), .ext_line_n(~{ev[11:8], ev[3], ev[1]}),
    .timer_a_ovf(ev[2]), .timer_b_ovf(ev[4]), .timer_c_ovf(ev[6]), .timer_c_ext(ev[13]),
    .serial_a_rx(ev[5]), .serial_a_tx(ev[14]), .serial_b_rx(ev[15]), .serial_b_tx(ev[7]),
    .watchdog_evt(ev[12]));
  flic_core_model CORE (.*);

  // Clock
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(string s, logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  // Bus write, each channel released when taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0, logic [3:0] s = 4'hF);
    logic ha, hw, hb;
    logic [1:0] br;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge aclk);
      ha = awready;
      hw = wready;
      hb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    chk("bresp", br, r);
  endtask

  // Bus read and compare
  task automatic rc(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'h0);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    hr = 1'h0;
    while (!hr) begin
      @(negedge aclk);
      ha = arready;
      hr = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    chk("rdata", d, e);
    chk("rresp", rr, r);
  endtask

  // One-cycle source event, optionally held
  task automatic fire(int i, logic hold);
    @(posedge aclk);
    ev[i] <= 1'h1;
    @(posedge aclk);
    ev[i] <= hold;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Wait for the next take and check its vector
  task automatic wt(logic [7:0] e);
    n = n + 8'h01;
    repeat (20) if (ntk !== n) @(negedge aclk);
    chk("taken", ntk, n);
    chk("vector", tv, e);
  endtask

  // Return from service
  task automatic rt;
    @(posedge aclk);
    ret <= 1'h1;
    @(posedge aclk);
    ret <= 1'h0;
    repeat (6) @(negedge aclk);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize;
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, allow, ret} = '0;
    {awaddr, araddr, wdata, wstrb, ev, n} = '0;
    ce = 1'h1;
    error_cnt = 0;
    checks = 0;
    aresetn = 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rc(`FLIC_ADDR_ENABLE, 32'h0);
    rc(`FLIC_ADDR_EXT_MODE, 32'h0);
    wr(`FLIC_ADDR_ENABLE, 32'hFFFF_FFFF, `FLIC_RESP_OKAY, 4'h2);
    rc(`FLIC_ADDR_ENABLE, 32'h3F00);
    wr(8'h20, 32'h1, `FLIC_RESP_SLVERR);
    rc(8'h20, 32'h0, `FLIC_RESP_SLVERR);
    $display("test reset done");
    fire(1, 1'h1);
    rc(`FLIC_ADDR_FLAGS, 32'h2);
    ev[1] <= 1'h0;
    rc(`FLIC_ADDR_FLAGS, 32'h0);
    fire(0, 1'h0);
    fire(4, 1'h0);
    rc(`FLIC_ADDR_FLAGS, 32'h11);
    @(negedge aclk);
    chk("request", core_irq_req, 1'h0);
    wr(`FLIC_ADDR_FLAGS, 32'hFFFF);
    rc(`FLIC_ADDR_FLAGS, 32'h0);
    ce <= 1'h0;
    fire(4, 1'h0);
    @(posedge aclk);
    ce <= 1'h1;
    rc(`FLIC_ADDR_FLAGS, 32'h0);
    $display("test flags done");
    wr(`FLIC_ADDR_EXT_MODE, 32'h3);
    wr(`FLIC_ADDR_ENABLE, 32'h3FFF);
    allow <= 1'h1;
    for (int i = 0; i < 13; i++) begin
      fire(i, 1'h0);
      wt(vt[i]);
      rc(`FLIC_ADDR_FLAGS, (i > 0 && i < 5) ? 32'h0 : 32'h1 << fp[i]);
      wr(`FLIC_ADDR_FLAGS, 32'hFFFF);
      rt;
    end
    for (int j = 13; j < 16; j++) begin
      fire(j, 1'h0);
      wt(vt[ai[j - 13]]);
      rc(`FLIC_ADDR_FLAGS, 32'h1 << ab[j - 13]);
      wr(`FLIC_ADDR_FLAGS, 32'hFFFF);
      rt;
    end
    $display("test vectors done");
    wr(`FLIC_ADDR_PRIO_LO, 32'h1204);
    wr(`FLIC_ADDR_PRIO_HI, 32'h1200);
    allow <= 1'h0;
    fire(12, 1'h0);
    fire(2, 1'h0);
    fire(9, 1'h0);
    chk("source", core_src, 4'h9);
    chk("level", core_level, 3'h3);
    rc(`FLIC_ADDR_STATUS, 32'h0097_004B);
    fire(0, 1'h0);
    chk("source", core_src, 4'h0);
    chk("level", core_level, 3'h4);
    @(posedge aclk);
    allow <= 1'h1;
    wt(8'h33);
    wr(`FLIC_ADDR_FLAGS, 32'hFFFF);
    rt;
    wr(`FLIC_ADDR_ENABLE, 32'h5);
    fire(2, 1'h0);
    chk("request", core_irq_req, 1'h0);
    fire(0, 1'h0);
    wt(8'h33);
    wr(`FLIC_ADDR_FLAGS, 32'hFFFF);
    rt;
    $display("test priority done");
    wr(`FLIC_ADDR_ENABLE, 32'h3FFF);
    wr(`FLIC_ADDR_EVT_STAT, 32'h3);
    wr(`FLIC_ADDR_EVT_MASK, 32'h1);
    wr(`FLIC_ADDR_PRIO_LO, 32'h4);
    wr(`FLIC_ADDR_PRIO_HI, 32'h100);
    @(negedge aclk);
    chk("irq", irq, 1'h0);
    fire(2, 1'h0);
    wt(8'h0B);
    chk("irq", irq, 1'h1);
    fire(4, 1'h0);
    chk("taken", ntk, n);
    fire(8, 1'h0);
    wt(8'h43);
    wr(`FLIC_ADDR_FLAGS, 32'h800);
    rt;
    chk("taken", ntk, n);
    rt;
    wt(8'h1B);
    rt;
    wr(`FLIC_ADDR_EVT_MASK, 32'h0);
    @(negedge aclk);
    chk("irq", irq, 1'h0);
    wr(`FLIC_ADDR_EVT_STAT, 32'h3);
    wr(`FLIC_ADDR_EVT_MASK, 32'h3);
    @(negedge aclk);
    chk("irq", irq, 1'h0);
    wr(`FLIC_ADDR_EVT_MASK, 32'h2);
    allow <= 1'h0;
    fire(0, 1'h0);
    chk("irq", irq, 1'h1);
    $display("test nesting done");
    summarize;
  end
endmodule
